// File: core/timer_chan_pkg.sv
// Shared constants, field layout and carrier types of the timer slice
package timer_chan_pkg;
  localparam int          NUM_CHAN    = 4;
  localparam int          CNT_W       = 16;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          REG_W       = 16;
  localparam int          CHAN_STRIDE = 4;
  localparam int          EN_POS      = 0;
  localparam int          POL_POS     = 1;
  localparam int          PSC_W       = 3;
  localparam int          WORD_LSB    = 2;
  localparam int          HALF_BIT    = 1;
  localparam logic [7:0]  CTRL_OFFSET = 8'h20;
  localparam logic [7:0]  CNT_OFFSET  = 8'h24;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] CTRL_WMASK  = 16'h3333;
  localparam logic [15:0] CNT_STEP    = 16'h0001;
  localparam logic        SIZE_HALF   = 1'h0;
  localparam logic        SIZE_WORD   = 1'h1;
  localparam logic [1:0]  PSC_DIV1    = 2'h0;
  localparam logic [1:0]  PSC_DIV2    = 2'h1;
  localparam logic [1:0]  PSC_DIV4    = 2'h2;
  localparam logic [2:0]  LIM_DIV1    = 3'h0;
  localparam logic [2:0]  LIM_DIV2    = 3'h1;
  localparam logic [2:0]  LIM_DIV4    = 3'h3;
  localparam logic [2:0]  LIM_DIV8    = 3'h7;

  typedef struct packed {
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic        size;
    logic [31:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic pol;
    logic en;
  } chan_ctrl_s;

  // Last edge count before a capture, per prescaler setting
  function automatic logic [2:0] psc_limit(input logic [1:0] sel);
    case (sel)
      PSC_DIV1: psc_limit = LIM_DIV1;
      PSC_DIV2: psc_limit = LIM_DIV2;
      PSC_DIV4: psc_limit = LIM_DIV4;
      default:  psc_limit = LIM_DIV8;
    endcase
  endfunction

  // Polarity and enable of one channel out of the control word
  function automatic chan_ctrl_s ctrl_field(input logic [15:0] r,
                                            input int          ch);
    chan_ctrl_s f;
    f.pol = r[ch * CHAN_STRIDE + POL_POS];
    f.en  = r[ch * CHAN_STRIDE + EN_POS];
    return f;
  endfunction
endpackage

// File: core/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic pin,
  output logic      level
);
  logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, lvl_q, lvl_d;

  always_comb begin
    s1_d  = pin;
    s2_d  = s1_q;
    s3_d  = s2_q;
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q  <= 1'h0;
      s2_q  <= 1'h0;
      s3_q  <= 1'h0;
      lvl_q <= 1'h0;
    end else if (ce) begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
endmodule

// File: core/chan_capture.sv
// Edge select, trigger polarity and capture prescaler of one channel
`timescale 1ns/10ps
module chan_capture
  import timer_chan_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       level,
  input  wire logic       polarity,
  input  wire logic       enable,
  input  wire logic       in_mode,
  input  wire logic [1:0] psc_sel,
  output logic            trigger,
  output logic            cap_pulse
);
  logic             trig_q, trig_d, cap_q, cap_d, edge_seen;
  logic [PSC_W-1:0] psc_q, psc_d;

  always_comb begin
    trig_d    = level ^ polarity;
    edge_seen = trig_d & ~trig_q;
    psc_d     = psc_q;
    cap_d     = 1'h0;
    if (!enable) begin
      psc_d = '0;
    end else if (in_mode && edge_seen) begin
      if (psc_q >= psc_limit(psc_sel)) begin
        psc_d = '0;
        cap_d = 1'h1;
      end else begin
        psc_d = psc_q + PSC_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trig_q <= 1'h0;
      cap_q  <= 1'h0;
      psc_q  <= '0;
    end else if (ce) begin
      trig_q <= trig_d;
      cap_q  <= cap_d;
      psc_q  <= psc_d;
    end
  end

  assign trigger   = trig_q;
  assign cap_pulse = cap_q;

  no_capture_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !enable |=> !cap_q)
    else $error("capture while channel disabled");
  psc_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !enable |=> psc_q == '0)
    else $error("prescaler not cleared by disable");
  trig_polarity_a: assert property (@(posedge core_clk) disable iff (rst)
    ce |=> trig_q == $past(level ^ polarity))
    else $error("trigger polarity wrong");
  edge_capture_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && enable && in_mode && psc_sel == PSC_DIV1
    && (level ^ polarity) && !trig_q |=> cap_q)
    else $error("selected edge not captured");
endmodule

// File: core/timer_channel_polarity_counter.sv
// Channel polarity/enable control and counter register of the timer
// Operation
// - Output polarity 0 active high, 1 active low
// - Input polarity 0 rising, 1 falling capture edge
// - Trigger passes inverted when polarity is 1
// - Output enable lets output follow compare, cleared holds it at 0
// - Input enable permits capture, cleared blocks it
// - Channel 0 enable bit 0, polarities 1,5,9,13
// - Enables of channels 1-3 at bits 4,8,12
// - Counter read returns the live count
// - Counter write replaces running count
// - Half-word and word accesses both accepted
// - Clearing enable resets capture prescaler
`timescale 1ns/10ps
module timer_channel_polarity_counter
  import timer_chan_pkg::*;
#(
  parameter int N_CHAN  = timer_chan_pkg::NUM_CHAN,
  parameter int COUNT_W = timer_chan_pkg::CNT_W
) (
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  input  wire logic                           ce,
  input  wire timer_chan_pkg::reg_req_s       reg_req,
  output logic [timer_chan_pkg::DATA_W-1:0]   reg_rdata,
  output logic                                reg_rvalid,
  input  wire logic                           count_enable,
  input  wire logic [N_CHAN-1:0]              chan_in_mode,
  input  wire logic [N_CHAN-1:0]              chan_cmp_ref,
  input  wire logic [N_CHAN-1:0][1:0]         chan_psc_sel,
  input  wire logic [N_CHAN-1:0]              chan_input_signal,
  output logic [N_CHAN-1:0]                   chan_output,
  output logic [N_CHAN-1:0]                   chan_trigger,
  output logic [N_CHAN-1:0]                   capture_event,
  output logic [N_CHAN-1:0][COUNT_W-1:0]      capture_value,
  output logic [COUNT_W-1:0]                  count_field
);
  import timer_chan_pkg::*;

  if (N_CHAN < 1 || N_CHAN > NUM_CHAN) begin : g_chan_check
    $error("N_CHAN must be 1 to 4");
  end
  if (COUNT_W < 1 || COUNT_W > REG_W) begin : g_cnt_check
    $error("COUNT_W must be 1 to 16");
  end

  // Register decode
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] off);
    return a[7:WORD_LSB] == off[7:WORD_LSB];
  endfunction

  // Upper half-word of a register lies above the 16 used bits
  function automatic logic low_half(input reg_req_s r);
    return (r.size == SIZE_WORD) || !r.addr[HALF_BIT];
  endfunction

  logic        ctrl_wr, cnt_wr, ctrl_rd, cnt_rd;
  logic [15:0] wdata16;

  always_comb begin
    wdata16 = reg_req.wdata[REG_W-1:0];
    ctrl_wr = reg_req.wr && addr_hit(reg_req.addr, CTRL_OFFSET)
              && low_half(reg_req);
    cnt_wr  = reg_req.wr && addr_hit(reg_req.addr, CNT_OFFSET)
              && low_half(reg_req);
    ctrl_rd = reg_req.rd && addr_hit(reg_req.addr, CTRL_OFFSET)
              && low_half(reg_req);
    cnt_rd  = reg_req.rd && addr_hit(reg_req.addr, CNT_OFFSET)
              && low_half(reg_req);
  end

  // Control register
  logic [15:0] ctrl_q, ctrl_d;

  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = wdata16 & CTRL_WMASK;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
    end
  end

  // Counter
  logic [COUNT_W-1:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (cnt_wr) begin
      cnt_d = wdata16[COUNT_W-1:0];
    end else if (count_enable) begin
      cnt_d = cnt_q + CNT_STEP[COUNT_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= CNT_RESET[COUNT_W-1:0];
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  assign count_field = cnt_q;

  // Read port
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              rvalid_q, rvalid_d;

  always_comb begin
    rdata_d  = '0;
    rvalid_d = reg_req.rd;
    if (ctrl_rd) begin
      rdata_d = {{(DATA_W-REG_W){1'h0}}, ctrl_q};
    end else if (cnt_rd) begin
      rdata_d = {{(DATA_W-COUNT_W){1'h0}}, cnt_q};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q  <= '0;
      rvalid_q <= 1'h0;
    end else if (ce) begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  // Channels
  chan_ctrl_s [N_CHAN-1:0]         cfg;
  logic [N_CHAN-1:0]               out_q, out_d;
  logic [N_CHAN-1:0]               lvl;
  logic [N_CHAN-1:0]               cap_pulse;
  logic [N_CHAN-1:0][COUNT_W-1:0]  capv_q, capv_d;

  always_comb begin
    for (int i = 0; i < N_CHAN; i++) begin
      cfg[i]    = ctrl_field(ctrl_q, i);
      out_d[i]  = 1'h0;
      capv_d[i] = capv_q[i];
      if (!chan_in_mode[i] && cfg[i].en) begin
        out_d[i] = chan_cmp_ref[i] ^ cfg[i].pol;
      end
      if (cap_pulse[i]) begin
        capv_d[i] = cnt_q;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_q  <= '0;
      capv_q <= '0;
    end else if (ce) begin
      out_q  <= out_d;
      capv_q <= capv_d;
    end
  end

  assign chan_output   = out_q;
  assign capture_event = cap_pulse;
  assign capture_value = capv_q;

  for (genvar g = 0; g < N_CHAN; g++) begin : g_chan
    pin_sync u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .pin      (chan_input_signal[g]),
      .level    (lvl[g])
    );

    chan_capture u_cap (
      .core_clk  (core_clk),
      .rst       (rst),
      .ce        (ce),
      .level     (lvl[g]),
      .polarity  (cfg[g].pol),
      .enable    (cfg[g].en),
      .in_mode   (chan_in_mode[g]),
      .psc_sel   (chan_psc_sel[g]),
      .trigger   (chan_trigger[g]),
      .cap_pulse (cap_pulse[g])
    );

    out_active_a: assert property (@(posedge core_clk) disable iff (rst)
      ce && !chan_in_mode[g] && cfg[g].en
      |=> chan_output[g] == $past(chan_cmp_ref[g] ^ cfg[g].pol))
      else $error("output active level wrong");

    out_disabled_a: assert property (@(posedge core_clk) disable iff (rst)
      ce && !cfg[g].en |=> !chan_output[g])
      else $error("disabled channel drives output");

    cap_latch_a: assert property (@(posedge core_clk) disable iff (rst)
      ce && cap_pulse[g] |=> capture_value[g] == $past(cnt_q))
      else $error("capture value not latched");

    cap_disabled_a: assert property (@(posedge core_clk) disable iff (rst)
      ce && !cfg[g].en ##1 ce && !cfg[g].en |-> !capture_event[g])
      else $error("capture on disabled channel");
  end

  // Register checks
  ctrl_write_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && ctrl_wr |=> ctrl_q == ($past(wdata16) & CTRL_WMASK))
    else $error("control write not stored");

  ctrl_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !ctrl_wr || !ce |=> $stable(ctrl_q))
    else $error("control changed without write");

  cnt_write_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && cnt_wr |=> cnt_q == $past(wdata16[COUNT_W-1:0]))
    else $error("counter write not applied");

  cnt_continue_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && cnt_wr ##1 ce && count_enable && !cnt_wr
    |=> cnt_q == $past(wdata16[COUNT_W-1:0], 2) + CNT_STEP[COUNT_W-1:0])
    else $error("counting did not resume from written value");

  cnt_step_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && count_enable && !cnt_wr
    |=> cnt_q == $past(cnt_q) + CNT_STEP[COUNT_W-1:0])
    else $error("counter did not step");

  cnt_read_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && cnt_rd |=> reg_rvalid
    && reg_rdata == {{(DATA_W-COUNT_W){1'h0}}, $past(cnt_q)})
    else $error("counter read not live value");

  half_access_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && reg_req.rd && reg_req.size == SIZE_HALF
    && !reg_req.addr[HALF_BIT] && addr_hit(reg_req.addr, CTRL_OFFSET)
    |=> reg_rdata == {{(DATA_W-REG_W){1'h0}}, $past(ctrl_q)})
    else $error("half-word control read wrong");

  freeze_a: assert property (@(posedge core_clk) disable iff (rst)
    !ce |=> $stable(cnt_q) && $stable(chan_output) && $stable(reg_rdata))
    else $error("state moved while clock enable low");
endmodule

// File: sim/tb_timer_channel_polarity_counter.sv
// Self-checking bench of the channel control and counter registers
`timescale 1ns/10ps
module tb_timer_channel_polarity_counter
  import timer_chan_pkg::*;
;
  logic                   core_clk;
  logic                   rst;
  logic                   ce;
  reg_req_s               reg_req;
  logic [DATA_W-1:0]      reg_rdata;
  logic                   reg_rvalid;
  logic                   count_enable;
  logic [3:0]             chan_in_mode;
  logic [3:0]             chan_cmp_ref;
  logic [3:0][1:0]        chan_psc_sel;
  logic [3:0]             chan_input_signal;
  logic [3:0]             chan_output;
  logic [3:0]             chan_trigger;
  logic [3:0]             capture_event;
  logic [3:0][CNT_W-1:0]  capture_value;
  logic [CNT_W-1:0]       count_field;
  logic [31:0]            exp_q[$];
  int                     cap_n[4];
  logic [CNT_W-1:0]       cap_exp[4];
  int                     n_fail;
  int                     cmp_count;

  timer_channel_polarity_counter u_timer_channel_polarity_counter (
    .core_clk          (core_clk),
    .rst               (rst),
    .ce                (ce),
    .reg_req           (reg_req),
    .reg_rdata         (reg_rdata),
    .reg_rvalid        (reg_rvalid),
    .count_enable      (count_enable),
    .chan_in_mode      (chan_in_mode),
    .chan_cmp_ref      (chan_cmp_ref),
    .chan_psc_sel      (chan_psc_sel),
    .chan_input_signal (chan_input_signal),
    .chan_output       (chan_output),
    .chan_trigger      (chan_trigger),
    .capture_event     (capture_event),
    .capture_value     (capture_value),
    .count_field       (count_field)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One register access; a read notes its expected data
  task automatic bus(input logic [7:0] a, input logic w, input logic s,
                     input logic [31:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wr: w, rd: !w, size: s, wdata: d};
    if (!w) begin
      exp_q.push_back(d);
    end
    @(posedge core_clk);
    reg_req <= '0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic pin(input int ch, input logic v);
    @(posedge core_clk);
    chan_input_signal[ch] <= v;
    settle(10);
  endtask

  // Read data monitor
  always @(posedge core_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("wrong value rdata expected none seen %h", reg_rdata);
      end else begin
        chk("rdata", exp_q.pop_front(), reg_rdata);
      end
    end
  end

  always @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (capture_event[i] === 1'b1) begin
        cap_n[i]++;
        cap_exp[i] = count_field;
      end
    end
  end

  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end

  initial begin
    logic [15:0] x;
    logic [3:0]  r;
    int          c0;
    rst = 1'b1;
    ce = 1'b1;
    reg_req = '0;
    count_enable = 1'b0;
    chan_in_mode = 4'h0;
    chan_cmp_ref = 4'h0;
    chan_psc_sel = '0;
    chan_input_signal = 4'h0;
    void'($urandom(53));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    bus(CTRL_OFFSET, 1'b0, SIZE_WORD, 32'h0000_0000);
    bus(CNT_OFFSET, 1'b0, SIZE_WORD, 32'h0000_0000);
    bus(CTRL_OFFSET, 1'b1, SIZE_WORD, 32'hFFFF_FFFF);
    bus(CTRL_OFFSET, 1'b0, SIZE_WORD, 32'h0000_3333);
    bus(CTRL_OFFSET, 1'b1, SIZE_HALF, 32'h0000_2211);
    bus(8'h22, 1'b1, SIZE_HALF, 32'h0000_FFFF);
    bus(CTRL_OFFSET, 1'b0, SIZE_HALF, 32'h0000_2211);
    bus(8'h22, 1'b0, SIZE_HALF, 32'h0000_0000);
    bus(8'h30, 1'b0, SIZE_WORD, 32'h0000_0000);
    // Counter load, read back and continue counting
    for (int k = 0; k < 2; k++) begin
      x = (k == 0) ? 16'($urandom) : 16'hFFFF;
      bus(CNT_OFFSET, 1'b1, SIZE_HALF, {16'h0000, x});
      bus(CNT_OFFSET, 1'b0, SIZE_WORD, {16'h0000, x});
      count_enable <= 1'b1;
      bus(CNT_OFFSET, 1'b1, SIZE_WORD, {16'h0000, x});
      #1;
      chk("count", {16'h0000, x}, {16'h0000, count_field});
      settle(1);
      chk("count", {16'h0000, x + CNT_STEP}, 32'(count_field));
      count_enable <= 1'b0;
    end
    // Clock enable low freezes the running counter
    @(posedge core_clk);
    ce <= 1'b0;
    count_enable <= 1'b1;
    settle(1);
    x = count_field;
    settle(4);
    chk("frozen", {16'h0000, x}, 32'(count_field));
    @(posedge core_clk);
    ce <= 1'b1;
    count_enable <= 1'b0;
    // Output polarity and enable on every channel
    for (int ch = 0; ch < 4; ch++) begin
      for (int k = 0; k < 8; k++) begin
        r = 4'($urandom);
        chan_cmp_ref <= r;
        bus(CTRL_OFFSET, 1'b1, SIZE_WORD,
            32'(k[1:0]) << (ch * CHAN_STRIDE));
        settle(2);
        chk("output", 32'(k[0] & (r[ch] ^ k[1])),
            32'(chan_output[ch]));
      end
    end
    // Capture edge and trigger polarity on every channel
    chan_in_mode <= 4'hF;
    count_enable <= 1'b1;
    for (int ch = 0; ch < 4; ch++) begin
      for (int p = 0; p < 2; p++) begin
        bus(CTRL_OFFSET, 1'b1, SIZE_WORD,
            32'({p[0], 1'b1}) << (ch * CHAN_STRIDE));
        settle(10);
        c0 = cap_n[ch];
        pin(ch, 1'b1);
        chk("trigger", 32'(!p[0]), 32'(chan_trigger[ch]));
        chk("output", 32'h0, 32'(chan_output[ch]));
        pin(ch, 1'b0);
        chk("trigger", 32'(p[0]), 32'(chan_trigger[ch]));
        chk("captures", 32'h1, 32'(cap_n[ch] - c0));
        chk("capval", 32'(cap_exp[ch]), 32'(capture_value[ch]));
      end
    end
    // Disabled channel takes no capture
    bus(CTRL_OFFSET, 1'b1, SIZE_WORD, 32'h0000_0000);
    settle(10);
    c0 = cap_n[0];
    pin(0, 1'b1);
    pin(0, 1'b0);
    chk("captures", 32'h0, 32'(cap_n[0] - c0));
    // Divide by two prescaler cleared by disable
    chan_psc_sel[0] <= PSC_DIV2;
    bus(CTRL_OFFSET, 1'b1, SIZE_WORD, 32'h0000_0001);
    settle(10);
    c0 = cap_n[0];
    pin(0, 1'b1);
    pin(0, 1'b0);
    bus(CTRL_OFFSET, 1'b1, SIZE_WORD, 32'h0000_0000);
    bus(CTRL_OFFSET, 1'b1, SIZE_WORD, 32'h0000_0001);
    settle(10);
    pin(0, 1'b1);
    pin(0, 1'b0);
    chk("captures", 32'h0, 32'(cap_n[0] - c0));
    pin(0, 1'b1);
    pin(0, 1'b0);
    chk("captures", 32'h1, 32'(cap_n[0] - c0));
    settle(4);
    chk("pending", 32'h0, 32'(exp_q.size()));
    wrap_up();
  end
endmodule
